// >>> ifc_pkg.sv
// Constants, register map and encodings shared by the flash control unit.
package ifc_pkg;

	// Register port widths.
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// Register offsets on the register port.
	localparam logic [3:0] OFS_KEY1_LOW  = 4'h0;
	localparam logic [3:0] OFS_KEY1_HIGH = 4'h1;
	localparam logic [3:0] OFS_KEY2_LOW  = 4'h2;
	localparam logic [3:0] OFS_KEY2_HIGH = 4'h3;
	localparam logic [3:0] OFS_KEY3_LOW  = 4'h4;
	localparam logic [3:0] OFS_KEY3_HIGH = 4'h5;
	localparam logic [3:0] OFS_OP_CTRL   = 4'h6;
	localparam logic [3:0] OFS_RST_PAT   = 4'h7;
	localparam logic [3:0] OFS_BUF_CTRL  = 4'h8;

	// Field positions in flash_op_control and write_buffer_control.
	localparam int BIT_UNLOCKED   = 7;
	localparam int SEL_MSB        = 6;
	localparam int SEL_LSB        = 4;
	localparam int BIT_TRIGGER    = 3;
	localparam int BIT_PROG_GO    = 2;
	localparam int BIT_READ_ALLOW = 1;
	localparam int BIT_READ_GO    = 0;
	localparam int BIT_FLUSH      = 0;

	// Value of every register after reset.
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Unlock key, one byte per key register.
	localparam logic [7:0] KEY1_LOW  = 8'h00;
	localparam logic [7:0] KEY2_LOW  = 8'h0d;
	localparam logic [7:0] KEY3_LOW  = 8'hc3;
	localparam logic [7:0] KEY1_HIGH = 8'h04;
	localparam logic [7:0] KEY2_HIGH = 8'h09;
	localparam logic [7:0] KEY3_HIGH = 8'h40;

	// Pattern that requests a whole-chip reset.
	localparam logic [7:0] CHIP_RESET_KEY = 8'h55;

	// Unlock procedure timer, in clock cycles.
	localparam int UNLOCK_CYCLES_DEF = 1024;
	localparam int TIMER_W           = 16;

	// Operation-select codes; 010, 100, 101 and 111 are reserved.
	typedef enum logic [2:0] {
		OP_WRITE      = 3'b000,
		OP_PAGE_ERASE = 3'b001,
		OP_READ       = 3'b011,
		OP_UNLOCK     = 3'b110
	} ifc_op_e;

	// Unlock procedure state.
	typedef enum logic [0:0] {
		UNL_IDLE  = 1'b0,
		UNL_ARMED = 1'b1
	} ifc_unlock_e;

endpackage

// >>> ifc_go_bit.sv
// Start bit that software sets and hardware clears when the process is done.
`timescale 1ns/100ps
module ifc_go_bit
	import ifc_pkg::*;
(
	// Clock and reset.
	input  wire logic clock,
	input  wire logic reset_n,
	// Software set request and completion from the flash side.
	input  wire logic setReq,
	input  wire logic done,
	// Bit state and one-cycle start pulse.
	output logic      goBit,
	output logic      start
);

	logic goBit_r;
	logic goBit_nxt;
	logic start_r;
	logic start_nxt;

	// A set while already running is ignored; completion only counts while running.
	assign goBit_nxt = goBit_r ? ~done : setReq;
	assign start_nxt = setReq & ~goBit_r;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			goBit_r <= 1'b0;
			start_r <= 1'b0;
		end
		else
		begin
			goBit_r <= goBit_nxt;
			start_r <= start_nxt;
		end
	end

	assign goBit = goBit_r;
	assign start = start_r;

endmodule // ifc_go_bit

// >>> ifc_flash_ctrl.sv
// Control and status logic for in-application flash programming.
//
// Behaviour
// [R01] Software writing one to the unlocked bit changes nothing.
// [R02] Software clearing the unlocked bit disables erase and write at once; a hardware set in the same cycle keeps the bit set.
// [R03] Hardware sets the unlocked bit only after a correct unlock.
// [R04] Select codes: 000 write, 001 erase, 011 read, 110 unlock.
// [R05] Software unlocks before any page erase or write.
// [R06] Trigger bit starts a timer; hardware clears it at timeout.
// [R07] Software writes the key before the unlock timer expires.
// [R08] Program-go starts erase or write; hardware clears it when done.
// [R09] Reads proceed only while read-allow is one.
// [R10] Read-go starts a read; hardware clears it when done.
// [R11] Software never sets program-go, read-allow and read-go in one write.
// [R12] CPU is stalled while a read, erase or write runs.
// [R13] Software checks the sub clock is stable before erase or write.
// [R14] Software waits for completion before starting another operation.
// [R15] Writing 55H to the reset pattern register resets the chip.
// [R16] Buffer-flush bit starts a clear; hardware clears it when done.
// [R17] Upper seven bits of buffer control read as zero.
// [R18] Six key registers are 8-bit read/write, zero after reset.
// [R19] Key is 00H 0DH C3H on low registers, 04H 09H 40H on high.
// [R20] A wrong key leaves erase and write disabled.
// [R21] Unlock timer length is a parameter in clock cycles.
`timescale 1ns/100ps
module ifc_flash_ctrl
	import ifc_pkg::*;
#(
	parameter int UNLOCK_CYCLES = UNLOCK_CYCLES_DEF
)
(
	// Clock and reset.
	input  wire logic              clock,
	input  wire logic              reset_n,
	// Register port.
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWrData,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic      [DATA_W-1:0] regRdData,
	// Flash array side.
	output logic      [2:0]        flashOpMode,
	output logic                   flashProgStart,
	input  wire logic              flashProgDone,
	output logic                   flashReadStart,
	input  wire logic              flashReadDone,
	output logic                   bufClearStart,
	input  wire logic              bufClearDone,
	// System side.
	output logic                   eraseWriteEnabled,
	output logic                   cpuStall,
	output logic                   chipResetReq
);

	// Key registers and control state.
	logic [7:0]         keyWord1Low_r;
	logic [7:0]         keyWord1High_r;
	logic [7:0]         keyWord2Low_r;
	logic [7:0]         keyWord2High_r;
	logic [7:0]         keyWord3Low_r;
	logic [7:0]         keyWord3High_r;
	logic [2:0]         opSel_r;
	logic               readAllow_r;
	logic               unlocked_r;
	logic               unlocked_nxt;
	logic [7:0]         rstPattern_r;
	logic               chipResetReq_r;
	logic               cpuStall_r;
	logic [DATA_W-1:0]  regRdData_r;
	logic [DATA_W-1:0]  regRdData_nxt;

	// Unlock procedure.
	ifc_unlock_e        unlockState_r;
	ifc_unlock_e        unlockState_nxt;
	logic [TIMER_W-1:0] unlockTimer_r;
	logic [TIMER_W-1:0] unlockTimer_nxt;

	// Address decode.
	wire selKey1Low  = (regAddr == OFS_KEY1_LOW);
	wire selKey1High = (regAddr == OFS_KEY1_HIGH);
	wire selKey2Low  = (regAddr == OFS_KEY2_LOW);
	wire selKey2High = (regAddr == OFS_KEY2_HIGH);
	wire selKey3Low  = (regAddr == OFS_KEY3_LOW);
	wire selKey3High = (regAddr == OFS_KEY3_HIGH);
	wire selOpCtrl   = (regAddr == OFS_OP_CTRL);
	wire selRstPat   = (regAddr == OFS_RST_PAT);
	wire selBufCtrl  = (regAddr == OFS_BUF_CTRL);

	wire wrOpCtrl  = regWrite & selOpCtrl;
	wire wrRstPat  = regWrite & selRstPat;
	wire wrBufCtrl = regWrite & selBufCtrl;

	// Fields of a control write.
	wire [2:0] wrSel       = regWrData[SEL_MSB:SEL_LSB];
	wire       wrUnlocked  = regWrData[BIT_UNLOCKED];
	wire       wrTrigger   = regWrData[BIT_TRIGGER];
	wire       wrProgGo    = regWrData[BIT_PROG_GO];
	wire       wrReadAllow = regWrData[BIT_READ_ALLOW];
	wire       wrReadGo    = regWrData[BIT_READ_GO];

	// Go bit state from the sequencers.
	logic progGo;
	logic readGo;
	logic flushGo;
	logic progStart;
	logic readStart;
	logic flushStart;

	// The mode a go bit acts on is the one already selected, not the one in the same write.
	wire selIsWrite = (opSel_r == OP_WRITE);
	wire selIsErase = (opSel_r == OP_PAGE_ERASE);
	wire selIsRead  = (opSel_r == OP_READ);
	wire selIsUnl   = (opSel_r == OP_UNLOCK);

	// [R11] Forbidden combined write
	// A write that sets all three start and enable bits at once is treated as malformed.
	wire allThreeSet = wrProgGo & wrReadAllow & wrReadGo;

	// Only one operation runs at a time; a request while another runs is dropped.
	wire anyBusy = progGo | readGo | flushGo;

	// [R08] Program-go start
	// [R03] Erase and write need the unlock
	wire progSetReq = wrOpCtrl & wrProgGo & ~allThreeSet & ~anyBusy & unlocked_r
		& (selIsWrite | selIsErase);

	// [R09] Read gate
	// [R10] Read-go start
	wire readSetReq = wrOpCtrl & wrReadGo & ~allThreeSet & ~anyBusy & readAllow_r
		& selIsRead;

	// [R16] Buffer flush start
	wire flushSetReq = wrBufCtrl & regWrData[BIT_FLUSH] & ~anyBusy;

	ifc_go_bit u_prog_go (
		.clock   (clock),
		.reset_n (reset_n),
		.setReq  (progSetReq),
		.done    (flashProgDone),
		.goBit   (progGo),
		.start   (progStart)
	);

	ifc_go_bit u_read_go (
		.clock   (clock),
		.reset_n (reset_n),
		.setReq  (readSetReq),
		.done    (flashReadDone),
		.goBit   (readGo),
		.start   (readStart)
	);

	ifc_go_bit u_flush_go (
		.clock   (clock),
		.reset_n (reset_n),
		.setReq  (flushSetReq),
		.done    (bufClearDone),
		.goBit   (flushGo),
		.start   (flushStart)
	);

	// [R19] Key comparison
	wire keyMatch = (keyWord1Low_r == KEY1_LOW) & (keyWord2Low_r == KEY2_LOW)
		& (keyWord3Low_r == KEY3_LOW) & (keyWord1High_r == KEY1_HIGH)
		& (keyWord2High_r == KEY2_HIGH) & (keyWord3High_r == KEY3_HIGH);

	// [R06] Trigger arms the timer
	wire unlockArm = wrOpCtrl & wrTrigger & selIsUnl & (unlockState_r == UNL_IDLE);
	wire timerDone = (unlockState_r == UNL_ARMED) & (unlockTimer_r == '0);

	// [R21] Timer length in cycles
	always_comb
	begin
		unlockState_nxt = unlockState_r;
		unlockTimer_nxt = unlockTimer_r;
		case (unlockState_r)
			UNL_IDLE:
			begin
				if (unlockArm)
				begin
					unlockState_nxt = UNL_ARMED;
					unlockTimer_nxt = TIMER_W'(UNLOCK_CYCLES - 1);
				end
			end
			UNL_ARMED:
			begin
				// [R06] Hardware clears trigger
				if (timerDone)
					unlockState_nxt = UNL_IDLE;
				else
					unlockTimer_nxt = unlockTimer_r - 1'b1;
			end
			default:
			begin
				unlockState_nxt = UNL_IDLE;
				unlockTimer_nxt = '0;
			end
		endcase
	end

	// The key is judged at timeout so that software may write it in any order.
	wire unlockSet = timerDone & keyMatch;

	// [R01] Write of one ignored
	// [R02] Software clear disables
	// [R20] Wrong key stays locked
	// A hardware set in the same cycle as a software clear wins.
	always_comb
	begin
		unlocked_nxt = unlocked_r;
		if (wrOpCtrl & ~wrUnlocked)
			unlocked_nxt = 1'b0;
		if (unlockSet)
			unlocked_nxt = 1'b1;
	end

	// [R18] Key registers
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			keyWord1Low_r  <= RST_BYTE;
			keyWord1High_r <= RST_BYTE;
			keyWord2Low_r  <= RST_BYTE;
			keyWord2High_r <= RST_BYTE;
			keyWord3Low_r  <= RST_BYTE;
			keyWord3High_r <= RST_BYTE;
		end
		else if (regWrite)
		begin
			if (selKey1Low)
				keyWord1Low_r <= regWrData;
			if (selKey1High)
				keyWord1High_r <= regWrData;
			if (selKey2Low)
				keyWord2Low_r <= regWrData;
			if (selKey2High)
				keyWord2High_r <= regWrData;
			if (selKey3Low)
				keyWord3Low_r <= regWrData;
			if (selKey3High)
				keyWord3High_r <= regWrData;
		end
	end

	// [R04] Operation select field
	// The select field is frozen while an operation runs so the flash sees a steady mode.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			opSel_r     <= OP_WRITE;
			readAllow_r <= 1'b0;
		end
		else if (wrOpCtrl & ~anyBusy)
		begin
			opSel_r     <= wrSel;
			readAllow_r <= wrReadAllow & ~allThreeSet;
		end
	end

	// Unlock state, timer and status bit.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			unlockState_r <= UNL_IDLE;
			unlockTimer_r <= '0;
			unlocked_r    <= 1'b0;
		end
		else
		begin
			unlockState_r <= unlockState_nxt;
			unlockTimer_r <= unlockTimer_nxt;
			unlocked_r    <= unlocked_nxt;
		end
	end

	// [R15] Chip reset pattern
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rstPattern_r   <= RST_BYTE;
			chipResetReq_r <= 1'b0;
		end
		else
		begin
			if (wrRstPat)
				rstPattern_r <= regWrData;
			chipResetReq_r <= wrRstPat & (regWrData == CHIP_RESET_KEY);
		end
	end

	// [R12] CPU stall
	// The stall starts in the cycle after the go bit is set and drops two cycles after done.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			cpuStall_r <= 1'b0;
		else
			cpuStall_r <= progGo | readGo;
	end

	// Read data multiplexer.
	wire [7:0] opCtrlView = {unlocked_r, opSel_r, (unlockState_r == UNL_ARMED),
		progGo, readAllow_r, readGo};

	// [R17] Upper buffer bits read zero
	wire [7:0] bufCtrlView = {7'h00, flushGo};

	always_comb
	begin
		regRdData_nxt = 8'h00;
		if (regRead)
		begin
			case (regAddr)
				OFS_KEY1_LOW:  regRdData_nxt = keyWord1Low_r;
				OFS_KEY1_HIGH: regRdData_nxt = keyWord1High_r;
				OFS_KEY2_LOW:  regRdData_nxt = keyWord2Low_r;
				OFS_KEY2_HIGH: regRdData_nxt = keyWord2High_r;
				OFS_KEY3_LOW:  regRdData_nxt = keyWord3Low_r;
				OFS_KEY3_HIGH: regRdData_nxt = keyWord3High_r;
				OFS_OP_CTRL:   regRdData_nxt = opCtrlView;
				OFS_RST_PAT:   regRdData_nxt = rstPattern_r;
				OFS_BUF_CTRL:  regRdData_nxt = bufCtrlView;
				default:       regRdData_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			regRdData_r <= 8'h00;
		else
			regRdData_r <= regRdData_nxt;
	end

	// Outputs, each from a flip-flop.
	assign regRdData         = regRdData_r;
	assign flashOpMode       = opSel_r;
	assign flashProgStart    = progStart;
	assign flashReadStart    = readStart;
	assign bufClearStart     = flushStart;
	assign eraseWriteEnabled = unlocked_r;
	assign cpuStall          = cpuStall_r;
	assign chipResetReq      = chipResetReq_r;

endmodule // ifc_flash_ctrl

// >>> ifc_flash_checker.sv
// Port-level assertions for the flash control unit.
`timescale 1ns/100ps
module ifc_flash_checker
	import ifc_pkg::*;
#(
	parameter int UNLOCK_CYCLES = UNLOCK_CYCLES_DEF
)
(
	// Clock, reset and register port.
	input wire logic              clock,
	input wire logic              reset_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic              regWrite,
	input wire logic              regRead,
	input wire logic [DATA_W-1:0] regRdData,
	// Flash and system side.
	input wire logic [2:0]        flashOpMode,
	input wire logic              flashProgStart,
	input wire logic              flashProgDone,
	input wire logic              flashReadStart,
	input wire logic              flashReadDone,
	input wire logic              bufClearStart,
	input wire logic              bufClearDone,
	input wire logic              eraseWriteEnabled,
	input wire logic              cpuStall,
	input wire logic              chipResetReq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	wire ctrlWr = regWrite && regAddr == OFS_OP_CTRL;
	wire anyStart = flashProgStart || flashReadStart || bufClearStart;
	unlock_clear_a: assert property (ctrlWr && !regWrData[BIT_UNLOCKED] |=> !eraseWriteEnabled)
		else $error("unlocked bit survived a clearing write");
	prog_gate_a: assert property (flashProgStart |-> $past(eraseWriteEnabled)
		&& $past(flashOpMode) inside {OP_WRITE, OP_PAGE_ERASE}) else $error("bad program start");
	read_gate_a: assert property (flashReadStart |-> $past(flashOpMode) == OP_READ)
		else $error("read started outside read mode");
	start_pulse_a: assert property (anyStart |=> !anyStart)
		else $error("start pulse longer than one cycle");
	stall_start_a: assert property (flashProgStart || flashReadStart |=> cpuStall)
		else $error("no stall after a start");
	stall_cause_a: assert property ($rose(cpuStall) |->
		$past(flashProgStart) || $past(flashReadStart)) else $error("stall without a start");
	done_end_a: assert property (cpuStall && (flashProgDone || flashReadDone) |-> ##2 !cpuStall)
		else $error("stall kept after completion");
	chip_reset_a: assert property (regWrite && regAddr == OFS_RST_PAT
		&& regWrData == CHIP_RESET_KEY |=> chipResetReq ##1 !chipResetReq) else $error("no reset pulse");
	buf_upper_a: assert property (regRead && regAddr == OFS_BUF_CTRL |=>
		regRdData[7:1] == 7'h00) else $error("buffer control upper bits not zero");
	cover property (flashProgStart);
	cover property (flashReadStart);
	cover property ($rose(eraseWriteEnabled));
endmodule // ifc_flash_checker

bind ifc_flash_ctrl ifc_flash_checker #(.UNLOCK_CYCLES(UNLOCK_CYCLES)) checker_i (
	.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
	.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .flashOpMode(flashOpMode),
	.flashProgStart(flashProgStart), .flashProgDone(flashProgDone),
	.flashReadStart(flashReadStart), .flashReadDone(flashReadDone),
	.bufClearStart(bufClearStart), .bufClearDone(bufClearDone),
	.eraseWriteEnabled(eraseWriteEnabled), .cpuStall(cpuStall), .chipResetReq(chipResetReq)
);

// >>> ifc_flash_model.sv
// Behavioural flash array that answers each start after a set delay.
`timescale 1ns/100ps
module ifc_flash_model
(
	// Clock, reset and answer delay in cycles.
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [7:0] lat,
	// Starts in, completions out.
	input  wire logic       flashProgStart,
	input  wire logic       flashReadStart,
	input  wire logic       bufClearStart,
	output logic            flashProgDone,
	output logic            flashReadDone,
	output logic            bufClearDone
);
	logic [7:0] busyCnt_r [3];
	wire  [2:0] startVec = {bufClearStart, flashReadStart, flashProgStart};
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			for (int i = 0; i < 3; i++)
				busyCnt_r[i] <= 8'h00;
		else
			for (int i = 0; i < 3; i++)
				if (startVec[i])
					busyCnt_r[i] <= lat;
				else if (busyCnt_r[i] != 8'h00)
					busyCnt_r[i] <= busyCnt_r[i] - 8'h01;
	end
	// Done is a single pulse, so a slow answer is never seen twice.
	assign flashProgDone = busyCnt_r[0] == 8'h01;
	assign flashReadDone = busyCnt_r[1] == 8'h01;
	assign bufClearDone  = busyCnt_r[2] == 8'h01;
endmodule // ifc_flash_model

// >>> ifc_tb.sv
// Self-checking bench for the flash control unit with a flash model.
`timescale 1ns/100ps
module tb
	import ifc_pkg::*;
;
	localparam int UL = 16;
	logic              clock = 1'b0;
	logic              reset_n = 1'b0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWrData = '0;
	logic              regWrite = 1'b0;
	logic              regRead = 1'b0;
	logic [7:0]        lat = 8'h02;
	logic [DATA_W-1:0] regRdData;
	logic [2:0]        flashOpMode;
	logic flashProgStart, flashProgDone, flashReadStart, flashReadDone;
	logic bufClearStart, bufClearDone, eraseWriteEnabled, cpuStall, chipResetReq;
	int                miscompares = 0;
	int                nTests = 0;
	ifc_flash_ctrl #(.UNLOCK_CYCLES(UL)) dut (.clock(clock), .reset_n(reset_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .flashOpMode(flashOpMode), .flashProgStart(flashProgStart),
		.flashProgDone(flashProgDone), .flashReadStart(flashReadStart),
		.flashReadDone(flashReadDone), .bufClearStart(bufClearStart), .bufClearDone(bufClearDone),
		.eraseWriteEnabled(eraseWriteEnabled), .cpuStall(cpuStall), .chipResetReq(chipResetReq));
	ifc_flash_model flash (.clock(clock), .reset_n(reset_n), .lat(lat),
		.flashProgStart(flashProgStart), .flashReadStart(flashReadStart),
		.bufClearStart(bufClearStart), .flashProgDone(flashProgDone),
		.flashReadDone(flashReadDone), .bufClearDone(bufClearDone));
	always #4 clock = ~clock;
	// Key byte for key register offset i, in offset order.
	function automatic logic [7:0] keyAt(input int i);
		case (i)
			0: keyAt = KEY1_LOW;
			1: keyAt = KEY1_HIGH;
			2: keyAt = KEY2_LOW;
			3: keyAt = KEY2_HIGH;
			4: keyAt = KEY3_LOW;
			default: keyAt = KEY3_HIGH;
		endcase
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nTests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		chk(regRdData, exp);
	endtask
	task automatic waitIdle();
		for (int n = 0; n < 100 && cpuStall !== 1'b0; n++)
			@(posedge clock);
		#1;
		chk(cpuStall, 1'b0); // stall released
	endtask
	task automatic t_reset();
		for (int a = 0; a < 16; a++)
			rd(a[3:0], 8'h00); // reset zero
		wr(OFS_OP_CTRL, 8'h80);
		rd(OFS_OP_CTRL, 8'h00); // set ignored
		for (int c = 0; c < 8; c++)
		begin
			wr(OFS_OP_CTRL, {1'b0, c[2:0], 4'h0});
			chk(flashOpMode, c[2:0]); // code stored
		end
	endtask
	task automatic t_unlock(input bit ok);
		wr(OFS_OP_CTRL, 8'h60);
		wr(OFS_OP_CTRL, 8'h68);
		rd(OFS_OP_CTRL, 8'h68); // trigger set
		for (int i = 0; i < 6; i++)
			wr(i[3:0], keyAt(i) ^ {7'h00, !ok});
		repeat (UL) @(posedge clock);
		rd(OFS_OP_CTRL, ok ? 8'he0 : 8'h60); // after timeout
		chk(eraseWriteEnabled, ok); // status output
		for (int i = 0; i < 6; i++)
			rd(i[3:0], keyAt(i) ^ {7'h00, !ok}); // key readback
	endtask
	task automatic t_prog(input logic [2:0] m);
		wr(OFS_OP_CTRL, {1'b1, m, 4'h0});
		wr(OFS_OP_CTRL, {1'b1, m, 4'h4});
		chk(flashProgStart, 1'b1); // start pulse
		rd(OFS_OP_CTRL, {1'b1, m, 4'h4}); // busy bit
		chk(cpuStall, 1'b1); // stall while programming
		waitIdle();
		rd(OFS_OP_CTRL, {1'b1, m, 4'h0}); // hardware clear
	endtask
	task automatic t_lock();
		wr(OFS_OP_CTRL, 8'h00);
		chk(eraseWriteEnabled, 1'b0); // cleared by write
		wr(OFS_OP_CTRL, 8'h04);
		chk(flashProgStart, 1'b0); // program refused
		rd(OFS_OP_CTRL, 8'h00); // go stays low
	endtask
	task automatic t_read();
		// allow and go in separate writes
		wr(OFS_OP_CTRL, 8'h32);
		wr(OFS_OP_CTRL, 8'h33);
		chk(flashReadStart, 1'b1); // read start
		rd(OFS_OP_CTRL, 8'h33); // busy bit
		chk(cpuStall, 1'b1); // stall while reading
		waitIdle();
		rd(OFS_OP_CTRL, 8'h32); // hardware clear
		wr(OFS_OP_CTRL, 8'h30);
		wr(OFS_OP_CTRL, 8'h31);
		chk(flashReadStart, 1'b0); // read blocked
		rd(OFS_OP_CTRL, 8'h30); // go refused
	endtask
	task automatic t_flush();
		wr(OFS_BUF_CTRL, 8'hfe);
		rd(OFS_BUF_CTRL, 8'h00); // upper bits zero
		wr(OFS_BUF_CTRL, 8'h01);
		chk(bufClearStart, 1'b1); // clear start
		rd(OFS_BUF_CTRL, 8'h01); // busy bit
		repeat (30) @(posedge clock);
		rd(OFS_BUF_CTRL, 8'h00); // hardware clear
	endtask
	task automatic t_chip();
		wr(OFS_RST_PAT, 8'h54);
		chk(chipResetReq, 1'b0); // other value
		wr(OFS_RST_PAT, 8'h55);
		chk(chipResetReq, 1'b1); // reset pulse
		rd(OFS_RST_PAT, 8'h55); // value kept
	endtask
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		t_reset();
		t_unlock(1'b0);
		t_unlock(1'b1);
		lat <= 8'h14;
		t_prog(OP_PAGE_ERASE);
		lat <= 8'h02;
		t_prog(OP_WRITE);
		t_lock();
		lat <= 8'h14;
		t_read();
		t_flush();
		t_chip();
		results();
	end
	// The whole sequence needs well under a thousand cycles.
	initial
	begin
		#100000;
		miscompares++;
		results();
	end
endmodule // tb
